// >>> rtl/ksc_top.sv
// Notes on behaviour
// - Chip select high: ignore clock, data; SDO off.
// - Shift SDI on SCLK falls, MSB first.
// - Frame holds exactly eight bits.
// - Wrong bit count: discard, keep settings.
// - Latch after eighth fall and select rise.
// - Integrate input high: frames ignored.
// - Prescaler high-impedance bit forces SDO off.
// - Integrate input defaults to hold.
// - Chip select active low, defaults inactive.
// - Clear integrator at each window start.
// - Integrate only while integrate is held.
// - Sixty-four gain settings, 0.111 to 2.0.
// - Band-pass gain two, 64 centre settings.
// - Sample selected channel, 10 bits, 200 kHz.
// - Divide oscillator input for sampling rate.
// - Serial setting picks one of two channels.
// - Integrator result drives 10-bit output converter.
// - Test input low selects test mode.
// - After power-up SDO echoes SDI.
// - Byte 010 sets prescaler and SDO state.
// - Bytes 00 and 10 load centre, gain.
`timescale 1ns/1ps
`default_nettype none
`include "ksc_consts.svh"
module ksc_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Serial port
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo_o,
   output logic sdo_oe,
   // Control pins
   input wire logic int_hold,
   input wire logic test_n,
   input wire logic oscillator_input,
   // Sample path
   input wire ksc_pkg::ksc_sample_t adc_sample,
   output logic sample_stb,
   output logic chan_sel,
   output ksc_pkg::ksc_code6_t bpf_centre,
   output ksc_pkg::ksc_code6_t gain_code,
   output ksc_pkg::ksc_tau_t tau_code,
   output ksc_pkg::ksc_presc_t presc_code,
   output logic [15:0] integ_out,
   output ksc_pkg::ksc_sample_t dac_code,
   // Status
   output logic adv_mode,
   output logic test_mode
);
   import ksc_pkg::*;

   logic rst_s1_r;
   logic rst_sync_n;
   logic cs_n_r;
   logic cs_n_d_r;
   logic sclk_r;
   logic sclk_d_r;
   logic sdi_r;
   logic hold_n_r;
   logic hold_n_d_r;
   logic hiz_r;
   logic adv_r;
   logic [7:0] shift_r;
   logic [7:0] resp_r;
   logic [7:0] last_byte_r;
   logic [3:0] bit_cnt_r;
   ksc_state_t state_r;
   ksc_state_t state_nxt;
   logic cs_fall;
   logic cs_rise;
   logic sclk_fall;
   logic frame_ok;
   logic win_start;
   ksc_sample_t samp_r;
   logic samp_vld_r;
   logic [9:0] rect_r;
   logic rect_vld_r;
   logic [12:0] bp_r;
   logic bp_vld_r;
   logic [15:0] acc_r;
   logic [15:0] gain_q8;
   logic [10:0] centred;
   logic [25:0] gained;
   logic [16:0] acc_sum;

   // Reset release goes through two stages so that every flop leaves reset together.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_sync_n <= rst_s1_r;
      end
   end

   // Pins are sampled once; reset values stand in for the internal pull resistors.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cs_n_r <= 1'b1;
         cs_n_d_r <= 1'b1;
         sclk_r <= 1'b0;
         sclk_d_r <= 1'b0;
         sdi_r <= 1'b1;
         hold_n_r <= 1'b0;
         hold_n_d_r <= 1'b0;
         test_mode <= 1'b0;
      end else begin
         cs_n_r <= cs_n;
         cs_n_d_r <= cs_n_r;
         sclk_r <= sclk;
         sclk_d_r <= sclk_r;
         sdi_r <= sdi;
         hold_n_r <= int_hold;
         hold_n_d_r <= hold_n_r;
         test_mode <= ~test_n;
      end
   end

   assign cs_fall = cs_n_d_r & ~cs_n_r;
   assign cs_rise = ~cs_n_d_r & cs_n_r;
   // Edges count only inside a frame; the host starts with the clock low.
   assign sclk_fall = sclk_d_r & ~sclk_r & (state_r == KSC_ST_FRAME);
   assign frame_ok = cs_rise & (state_r == KSC_ST_FRAME) & (bit_cnt_r == `KSC_FRAME_BITS) &
                     ~hold_n_r;
   assign win_start = hold_n_r & ~hold_n_d_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         KSC_ST_IDLE: begin
            if (cs_fall) begin
               state_nxt = KSC_ST_FRAME;
            end
         end
         KSC_ST_FRAME: begin
            if (cs_rise) begin
               state_nxt = KSC_ST_IDLE;
            end
         end
         default: state_nxt = KSC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_r <= KSC_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The counter saturates so that long frames can never wrap back to eight.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
      end else if (cs_fall) begin
         bit_cnt_r <= 4'h0;
      end else if (sclk_fall) begin
         shift_r <= {shift_r[6:0], sdi_r};
         if (bit_cnt_r != `KSC_CNT_SAT) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
      end
   end

   // Command decode happens only on an accepted frame.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         presc_code <= `KSC_PRESC_RST;
         hiz_r <= `KSC_HIZ_RST;
         chan_sel <= `KSC_CHAN_RST;
         bpf_centre <= `KSC_BPF_RST;
         gain_code <= `KSC_GAIN_RST;
         tau_code <= `KSC_TAU_RST;
         adv_r <= 1'b0;
         last_byte_r <= 8'h00;
      end else if (frame_ok) begin
         last_byte_r <= shift_r;
         if (shift_r == `KSC_OP_ADV) begin
            adv_r <= 1'b1;
         end else if (shift_r[7:1] == `KSC_OP_CHAN) begin
            chan_sel <= shift_r[0];
         end else if (shift_r[7:6] == `KSC_OP_BPF) begin
            bpf_centre <= shift_r[5:0];
         end else if (shift_r[7:6] == `KSC_OP_GAIN) begin
            gain_code <= shift_r[5:0];
         end else if (shift_r[7:5] == `KSC_OP_TAU) begin
            tau_code <= shift_r[4:0];
         end else if (shift_r[7:5] == `KSC_OP_PRESC) begin
            presc_code <= shift_r[4:1];
            hiz_r <= shift_r[0];
         end
      end
   end

   // Advanced mode sends back the previous byte; its other features are not built.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         resp_r <= 8'h00;
      end else if (cs_fall) begin
         resp_r <= last_byte_r;
      end else if (sclk_fall) begin
         resp_r <= {resp_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sdo_o <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo_o <= adv_r ? resp_r[7] : sdi;
         sdo_oe <= ~cs_n & ~hiz_r;
      end
   end

   assign adv_mode = adv_r;

   ksc_prescaler u_presc (
      .clock(clock),
      .rst_sync_n(rst_sync_n),
      .oscillator_input(oscillator_input),
      .presc_code(presc_code),
      .sample_stb(sample_stb)
   );

   // Gain steps are linear in Q8; the analog stage owns the true curve.
   assign gain_q8 = `KSC_GAIN_LO_Q8 +
                    16'((16'(gain_code) * `KSC_GAIN_SPAN_Q8) / `KSC_GAIN_STEPS);
   assign centred = {1'b0, samp_r} - `KSC_ADC_MID;
   assign gained = 26'(rect_r) * 26'(gain_q8);
   assign acc_sum = {1'b0, acc_r} + 17'(bp_r / (13'(tau_code) + 13'h0001));

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         samp_r <= 10'h000;
         samp_vld_r <= 1'b0;
         rect_r <= 10'h000;
         rect_vld_r <= 1'b0;
         bp_r <= 13'h0000;
         bp_vld_r <= 1'b0;
      end else begin
         samp_vld_r <= sample_stb;
         if (sample_stb) begin
            samp_r <= adc_sample;
         end
         rect_vld_r <= samp_vld_r;
         if (samp_vld_r) begin
            rect_r <= centred[10] ? 10'(-centred) : centred[9:0];
         end
         bp_vld_r <= rect_vld_r;
         if (rect_vld_r) begin
            bp_r <= {gained[19:8], 1'b0};
         end
      end
   end

   // The accumulator clamps instead of wrapping, like the analog integrator.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         acc_r <= 16'h0000;
      end else if (win_start) begin
         acc_r <= 16'h0000;
      end else if (hold_n_r && bp_vld_r) begin
         acc_r <= acc_sum[16] ? `KSC_ACC_MAX : acc_sum[15:0];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dac_code <= 10'h000;
         integ_out <= 16'h0000;
      end else begin
         dac_code <= acc_r[15:6];
         integ_out <= acc_r;
      end
   end

   property p_cs_off;
      @(posedge clock) disable iff (!rst_sync_n) cs_n |=> !sdo_oe;
   endproperty
   a_cs_off: assert property (p_cs_off) else $error("SDO driven while deselected");

   property p_hiz;
      @(posedge clock) disable iff (!rst_sync_n) hiz_r |=> !sdo_oe;
   endproperty
   a_hiz: assert property (p_hiz) else $error("SDO driven in high impedance");

   property p_shift;
      @(posedge clock) disable iff (!rst_sync_n)
         sclk_fall && !cs_fall |=> shift_r == {$past(shift_r[6:0]), $past(sdi_r)};
   endproperty
   a_shift: assert property (p_shift) else $error("Shift register missed a bit");

   property p_bad_count;
      @(posedge clock) disable iff (!rst_sync_n)
         cs_rise && bit_cnt_r != `KSC_FRAME_BITS |=>
            $stable(gain_code) && $stable(bpf_centre) && $stable(tau_code) && $stable(presc_code);
   endproperty
   a_bad_count: assert property (p_bad_count) else $error("Bad frame took effect");

   property p_latch_when;
      @(posedge clock) disable iff (!rst_sync_n)
         !$stable(gain_code) |-> $past(cs_rise) && $past(bit_cnt_r) == `KSC_FRAME_BITS;
   endproperty
   a_latch_when: assert property (p_latch_when) else $error("Latched off frame end");

   property p_integ_ignore;
      @(posedge clock) disable iff (!rst_sync_n)
         cs_rise && hold_n_r |=> $stable(chan_sel) && $stable(gain_code) && $stable(adv_r);
   endproperty
   a_integ_ignore: assert property (p_integ_ignore) else $error("Frame not ignored");

   property p_clear;
      @(posedge clock) disable iff (!rst_sync_n)
         win_start |=> acc_r == 16'h0000 ##1 dac_code == 10'h000;
   endproperty
   a_clear: assert property (p_clear) else $error("Integrator not cleared at window");

   property p_hold_keep;
      @(posedge clock) disable iff (!rst_sync_n) !hold_n_r && !win_start |=> $stable(acc_r);
   endproperty
   a_hold_keep: assert property (p_hold_keep) else $error("Integrator moved in hold");

   property p_echo;
      @(posedge clock) disable iff (!rst_sync_n) rst_sync_n && !adv_r |=> sdo_o == $past(sdi);
   endproperty
   a_echo: assert property (p_echo) else $error("SDO does not echo SDI");

   property p_test;
      @(posedge clock) disable iff (!rst_sync_n) ##1 test_mode == !$past(test_n);
   endproperty
   a_test: assert property (p_test) else $error("Test mode not following pin");
endmodule
`default_nettype wire

// >>> pkg/ksc_consts.svh
`ifndef KSC_CONSTS_SVH
`define KSC_CONSTS_SVH

`define KSC_FRAME_BITS 4'h8
`define KSC_CNT_SAT 4'hF
`define KSC_OP_PRESC 3'b010
`define KSC_OP_CHAN 7'b1110000
`define KSC_OP_BPF 2'b00
`define KSC_OP_GAIN 2'b10
`define KSC_OP_TAU 3'b110
`define KSC_OP_ADV 8'h71
`define KSC_PRESC_RST 4'h0
`define KSC_PRESC_MAX 4'h8
`define KSC_HIZ_RST 1'b0
`define KSC_CHAN_RST 1'b0
`define KSC_BPF_RST 6'h00
`define KSC_GAIN_RST 6'h00
`define KSC_TAU_RST 5'h00
`define KSC_FS_KHZ 200
`define KSC_ADC_MID 11'h200
`define KSC_GAIN_LO_Q8 16'h001C
`define KSC_GAIN_SPAN_Q8 16'h01E4
`define KSC_GAIN_STEPS 16'h003F
`define KSC_ACC_MAX 16'hFFFF

`endif

// >>> pkg/ksc_pkg.sv
package ksc_pkg;
   typedef enum logic [1:0] {
      KSC_ST_IDLE = 2'b01,
      KSC_ST_FRAME = 2'b10
   } ksc_state_t;
   typedef logic [3:0] ksc_presc_t;
   typedef logic [5:0] ksc_code6_t;
   typedef logic [4:0] ksc_tau_t;
   typedef logic [9:0] ksc_sample_t;
endpackage

// >>> rtl/ksc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "ksc_consts.svh"
module ksc_prescaler (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_sync_n,
   // Oscillator and setting
   input wire logic oscillator_input,
   input wire ksc_pkg::ksc_presc_t presc_code,
   // Converter timing
   output logic sample_stb
);
   import ksc_pkg::*;

   // Codes above the table fall back to the lowest input rate.
   function automatic logic [7:0] div_of(input ksc_presc_t code);
      int mhz;
      mhz = 4;
      unique case (code)
         4'h0: mhz = 4;
         4'h1: mhz = 5;
         4'h2: mhz = 6;
         4'h3: mhz = 8;
         4'h4: mhz = 10;
         4'h5: mhz = 12;
         4'h6: mhz = 16;
         4'h7: mhz = 20;
         4'h8: mhz = 24;
         default: mhz = 4;
      endcase
      div_of = 8'((mhz * 1000) / `KSC_FS_KHZ);
   endfunction

   logic osc_r;
   logic osc_d_r;
   logic [7:0] div_cnt_r;
   logic osc_rise;

   assign osc_rise = osc_r & ~osc_d_r;

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         osc_r <= 1'b0;
         osc_d_r <= 1'b0;
      end else begin
         osc_r <= oscillator_input;
         osc_d_r <= osc_r;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         div_cnt_r <= 8'h00;
         sample_stb <= 1'b0;
      end else begin
         sample_stb <= 1'b0;
         if (osc_rise) begin
            if (div_cnt_r >= div_of(presc_code) - 8'h01) begin
               div_cnt_r <= 8'h00;
               sample_stb <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 8'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/ksc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ksc_host_model (
   // Clock
   input wire logic clock,
   // Serial lines
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic last_r;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b1;
      last_r = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // An undriven SDO reads as the inverse of its last level, so a stale bit never passes.
   task automatic frame(input logic [15:0] data, input int nbits,
                        output logic [7:0] rx, output logic oe_all);
      rx = 8'h00;
      oe_all = 1'b1;
      tick(1);
      cs_n = 1'b0;
      tick(4);
      for (int i = 0; i < nbits; i++) begin
         sdi = data[15 - i];
         tick(4);
         sclk = 1'b1;
         tick(2);
         last_r = sdo_oe ? sdo_o : ~last_r;
         rx = {rx[6:0], last_r};
         oe_all = oe_all & sdo_oe;
         tick(2);
         sclk = 1'b0;
         tick(4);
      end
      cs_n = 1'b1;
      sdi = 1'b1;
      tick(8);
   endtask
   // Clock and data activity while deselected.
   task automatic noise();
      for (int i = 0; i < 16; i++) begin
         sclk = ~sclk;
         sdi = ~sdi;
         tick(3);
      end
   endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ksc_consts.svh"
module testbench;
   logic clock = 1'b0;
   logic rst_n, int_hold, test_n, osc = 1'b0;
   realtime osc_half = 125.0;
   ksc_pkg::ksc_sample_t adc_sample;
   wire cs_n, sclk, sdi;
   logic sdo_o, sdo_oe, sample_stb, chan_sel, adv_mode, test_mode, oe;
   ksc_pkg::ksc_code6_t bpf_centre, gain_code;
   ksc_pkg::ksc_tau_t tau_code;
   ksc_pkg::ksc_presc_t presc_code;
   logic [15:0] integ_out, held;
   ksc_pkg::ksc_sample_t dac_code;
   logic [7:0] rx;
   logic [22:0] exp_s, prev;
   logic [22:0] notes[$];
   logic [31:0] seed;
   int failures = 0, total_checks = 0, cycles = 0, gap;
   always #2 clock = ~clock;
   always #(osc_half) osc = ~osc;
   ksc_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .sdo_o(sdo_o), .sdo_oe(sdo_oe));
   ksc_top uut (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .sdo_o(sdo_o), .sdo_oe(sdo_oe), .int_hold(int_hold), .test_n(test_n),
      .oscillator_input(osc), .adc_sample(adc_sample), .sample_stb(sample_stb),
      .chan_sel(chan_sel), .bpf_centre(bpf_centre), .gain_code(gain_code),
      .tau_code(tau_code), .presc_code(presc_code), .integ_out(integ_out),
      .dac_code(dac_code), .adv_mode(adv_mode), .test_mode(test_mode));
   function automatic logic [22:0] snap();
      return {adv_mode, chan_sel, bpf_centre, gain_code, tau_code, presc_code};
   endfunction
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // Notes the expected settings, then sends one whole byte.
   task automatic cmd(input logic [7:0] b);
      logic [22:0] nx;
      nx = exp_s;
      if (b == `KSC_OP_ADV) nx[22] = 1'b1;
      else if (b[7:1] == `KSC_OP_CHAN) nx[21] = b[0];
      else if (b[7:6] == `KSC_OP_BPF) nx[20:15] = b[5:0];
      else if (b[7:6] == `KSC_OP_GAIN) nx[14:9] = b[5:0];
      else if (b[7:5] == `KSC_OP_TAU) nx[8:4] = b[4:0];
      else if (b[7:5] == `KSC_OP_PRESC) nx[3:0] = b[4:1];
      if (nx !== exp_s) notes.push_back(nx);
      exp_s = nx;
      host.frame({b, 8'h00}, 8, rx, oe);
   endtask
   task automatic next_stb();
      gap = 1;
      @(negedge clock);
      while (sample_stb !== 1'b1 && gap < 4000) begin
         @(negedge clock);
         gap++;
      end
   endtask
   task automatic reset_dut();
      rst_n = 1'b0;
      repeat (6) @(negedge clock);
      rst_n = 1'b1;
      exp_s = 23'h000000;
      repeat (4) @(negedge clock);
   endtask
   // A settings change is a result; it must match the oldest note.
   always @(posedge clock) begin
      if (!rst_n) begin
         prev = snap();
      end else if (snap() !== prev) begin
         prev = snap();
         check(notes.size() > 0 && prev === notes.pop_front(), "setting");
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      rst_n = 1'b0;
      int_hold = 1'b0;
      test_n = 1'b1;
      adc_sample = 10'h300;
      seed = 32'hB19F0300;
      reset_dut();
      check(snap() === 23'h000000, "reset state");
      cmd(8'h85);
      check(rx === 8'h85 && oe === 1'b1, "echo");
      check(sdo_oe === 1'b0, "sdo idle");
      cmd(8'h2A);
      cmd(8'hDF);
      cmd(8'hE1);
      cmd(8'hE0);
      cmd(8'h7F);
      cmd(8'hF3);
      cmd(8'hE5);
      host.frame(16'h9500, 7, rx, oe);
      host.frame(16'h9500, 9, rx, oe);
      check(snap() === exp_s, "short or long frame");
      host.noise();
      cmd(8'h91);
      int_hold = 1'b1;
      host.frame(16'h8C00, 8, rx, oe);
      int_hold = 1'b0;
      repeat (6) @(negedge clock);
      check(snap() === exp_s, "frame in integrate");
      for (int i = 0; i < 4; i++) cmd(8'h80 | 8'(xs() & 32'h0000003F));
      osc_half = 62.5;
      cmd(8'h47);
      cmd(8'h83);
      check(oe === 1'b0, "sdo forced off");
      next_stb();
      next_stb();
      check(gap >= 1249 && gap <= 1251, "rate 8 MHz");
      osc_half = 125.0;
      cmd(8'h40);
      next_stb();
      next_stb();
      check(gap >= 1249 && gap <= 1251, "rate 4 MHz");
      cmd(8'hBF);
      cmd(8'hC0);
      int_hold = 1'b1;
      next_stb();
      next_stb();
      int_hold = 1'b0;
      repeat (10) @(negedge clock);
      held = integ_out;
      next_stb();
      repeat (10) @(negedge clock);
      check(integ_out === held && held !== 16'h0000, "hold");
      adc_sample = 10'(xs());
      int_hold = 1'b1;
      repeat (4) @(negedge clock);
      check(integ_out === 16'h0000, "window clear");
      next_stb();
      repeat (10) @(negedge clock);
      held = (adc_sample > 10'h200) ? adc_sample - 10'h200 : 10'h200 - adc_sample;
      check(integ_out === held * 4, "one step");
      check(dac_code === integ_out[15:6], "dac");
      int_hold = 1'b0;
      test_n = 1'b0;
      repeat (3) @(negedge clock);
      check(test_mode === 1'b1, "test mode");
      test_n = 1'b1;
      cmd(8'h71);
      cmd(8'h9A);
      check(rx === 8'h71, "previous byte");
      cmd(8'h05);
      check(rx === 8'h9A, "previous byte");
      reset_dut();
      check(snap() === 23'h000000, "second reset");
      cmd(8'h85);
      check(rx === 8'h85, "echo again");
      check(notes.size() == 0, "notes left");
      end_of_test();
   end
endmodule
`default_nettype wire
